//--- rtl/svdd_defines.svh
`ifndef SVDD_DEFINES_SVH
`define SVDD_DEFINES_SVH

// Host register offsets, one 16-bit word each.
`define SVDD_OFS_STATUS 8'h04
`define SVDD_OFS_ACT_WORDS 8'h0e
`define SVDD_OFS_TOT_WORDS 8'h0f
`define SVDD_OFS_TOT_LINES 8'h10
`define SVDD_OFS_FLD_LINES 8'h11

// Status word field positions.
`define SVDD_STD_MSB 14
`define SVDD_STD_LSB 10
`define SVDD_LOCK_BIT 8
`define SVDD_FMT_MSB 3
`define SVDD_FMT_LSB 0

// Reset values.
`define SVDD_STATUS_RST 16'h000f
`define SVDD_WORDS_RST 12'h000
`define SVDD_LINES_RST 11'h000

// Raster figures used by the classifier.
`define SVDD_TOT_525 12'h6b4
`define SVDD_TOT_625 12'h6c0
`define SVDD_ACT_1440 12'h5a0
`define SVDD_LINES_525 11'h20d
`define SVDD_LINES_625 11'h271
`define SVDD_ACT_487 11'h1e7
`define SVDD_ACT_507 11'h1fb

// Line timing: reference word length and the update line.
`define SVDD_TRS_LEN 12'h004
`define SVDD_UPDATE_LINE 11'h00c
`define SVDD_FIRST_LINE 11'h001

`endif

//--- rtl/svdd_pkg.sv
package svdd_pkg;

  // Detected standard codes.
  typedef enum logic [4:0] {
    SVDD_STD_NONE = 5'h00,
    SVDD_STD_525_487 = 5'h16,
    SVDD_STD_525_507 = 5'h17,
    SVDD_STD_625_1440 = 5'h18,
    SVDD_STD_525_487_GEN = 5'h19,
    SVDD_STD_625_GEN = 5'h1a,
    SVDD_STD_525_507_GEN = 5'h1b,
    SVDD_STD_UNKNOWN = 5'h1e
  } svdd_std_t;

  // Data format codes; 8h to Eh are never produced.
  typedef enum logic [3:0] {
    SVDD_FMT_TAPE_NOECC = 4'h0,
    SVDD_FMT_TAPE_ECC = 4'h1,
    SVDD_FMT_TAPE_B = 4'h2,
    SVDD_FMT_CONTENT_PKG = 4'h3,
    SVDD_FMT_FIXED_BLK = 4'h4,
    SVDD_FMT_VAR_BLK = 4'h5,
    SVDD_FMT_SDI = 4'h6,
    SVDD_FMT_ASI = 4'h7,
    SVDD_FMT_UNKNOWN = 4'hf
  } svdd_fmt_t;

  typedef logic [11:0] svdd_words_t;
  typedef logic [10:0] svdd_lines_t;

endpackage

//--- rtl/svdd_meas_if.sv
interface svdd_meas_if;
  import svdd_pkg::*;

  // One-cycle pulse at the end of line 12 plus the measured raster.
  logic upd;
  svdd_words_t act_words;
  svdd_words_t tot_words;
  svdd_lines_t tot_lines;
  svdd_lines_t fld_act_lines;
  svdd_lines_t frm_act_lines;

  modport meter (output upd, act_words, tot_words, tot_lines,
    fld_act_lines, frm_act_lines);
  modport core (input upd, act_words, tot_words, tot_lines,
    fld_act_lines, frm_act_lines);
endinterface

//--- rtl/svdd_raster_meter.sv
`include "svdd_defines.svh"

module svdd_raster_meter
  import svdd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trs_valid_i,
  input wire logic trs_eav_i,
  input wire logic trs_f_i,
  input wire logic trs_v_i,
  svdd_meas_if.meter meas
);

  svdd_words_t word_cnt_reg, act_cnt_reg, tot_words_reg, act_words_reg;
  svdd_lines_t line_cnt_reg, frm_cnt_reg, fld_cnt_reg;
  svdd_lines_t tot_lines_reg, frm_act_reg, fld_act_reg;
  logic f_prev_reg, upd_reg;

  // Reference word decode; a frame starts where F falls to zero.
  wire eav = trs_valid_i & trs_eav_i;
  wire sav = trs_valid_i & ~trs_eav_i;
  wire frame_start = eav & f_prev_reg & ~trs_f_i;
  wire act_line = ~trs_v_i;
  wire fld1_act = ~trs_v_i & ~trs_f_i;

  // Words are counted from each EAV, active words from each SAV.
  wire svdd_words_t word_cnt_next = eav ? `SVDD_WORDS_RST
    : word_cnt_reg + 12'h001;
  wire svdd_words_t act_cnt_next = sav ? `SVDD_WORDS_RST
    : act_cnt_reg + 12'h001;
  wire svdd_lines_t line_cnt_next = frame_start ? `SVDD_FIRST_LINE
    : eav ? line_cnt_reg + 11'h001 : line_cnt_reg;
  wire svdd_lines_t frm_cnt_next = frame_start ? {10'h000, act_line}
    : (eav & act_line) ? frm_cnt_reg + 11'h001 : frm_cnt_reg;
  wire svdd_lines_t fld_cnt_next = frame_start ? {10'h000, fld1_act}
    : (eav & fld1_act) ? fld_cnt_reg + 11'h001 : fld_cnt_reg;

  // Counters and the per-line captures; the four SAV reference words are excluded.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      word_cnt_reg <= `SVDD_WORDS_RST;
      act_cnt_reg <= `SVDD_WORDS_RST;
      tot_words_reg <= `SVDD_WORDS_RST;
      act_words_reg <= `SVDD_WORDS_RST;
      line_cnt_reg <= `SVDD_LINES_RST;
      frm_cnt_reg <= `SVDD_LINES_RST;
      fld_cnt_reg <= `SVDD_LINES_RST;
      f_prev_reg <= 1'b0;
    end else begin
      word_cnt_reg <= word_cnt_next;
      act_cnt_reg <= act_cnt_next;
      line_cnt_reg <= line_cnt_next;
      frm_cnt_reg <= frm_cnt_next;
      fld_cnt_reg <= fld_cnt_next;
      if (trs_valid_i) f_prev_reg <= trs_f_i;
      if (eav) begin
        tot_words_reg <= word_cnt_reg + 12'h001;
        // The SAV word itself counts as zero, so one is added back.
        act_words_reg <= act_cnt_reg + 12'h001 - `SVDD_TRS_LEN;
      end
    end
  end

  // Frame totals are captured at the frame boundary, then published
  // at the end of line 12 so that every field is complete.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tot_lines_reg <= `SVDD_LINES_RST;
      frm_act_reg <= `SVDD_LINES_RST;
      fld_act_reg <= `SVDD_LINES_RST;
      upd_reg <= 1'b0;
    end else begin
      if (frame_start) begin
        tot_lines_reg <= line_cnt_reg;
        frm_act_reg <= frm_cnt_reg;
        fld_act_reg <= fld_cnt_reg;
      end
      upd_reg <= eav && (line_cnt_reg == `SVDD_UPDATE_LINE);
    end
  end

  assign meas.upd = upd_reg;
  assign meas.act_words = act_words_reg;
  assign meas.tot_words = tot_words_reg;
  assign meas.tot_lines = tot_lines_reg;
  assign meas.fld_act_lines = fld_act_reg;
  assign meas.frm_act_lines = frm_act_reg;

endmodule // svdd_raster_meter

//--- rtl/svdd_std_detector.sv
`include "svdd_defines.svh"

module svdd_std_detector
  import svdd_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic TRS_VALID_I,
  input wire logic TRS_EAV_I,
  input wire logic TRS_F_I,
  input wire logic TRS_V_I,
  input wire logic LOCKED_I,
  input wire logic VIDEO_PROCESSING_BYPASS_N_I,
  input wire logic DATA_THROUGH_I,
  input wire logic FLYWHEEL_FULL_SYNC_I,
  input wire logic SIGNAL_PRESENT_I,
  input wire logic ASI_MODE_I,
  input wire logic SDTI_VALID_I,
  input wire logic [2:0] SDTI_FORMAT_I,
  input wire logic [7:0] HOST_ADDR_I,
  input wire logic HOST_RD_I,
  input wire logic HOST_WR_I,
  output logic [15:0] HOST_RDATA_O,
  output logic HOST_RVALID_O,
  output logic PAYLOAD_ID_CLEAR_O
);

  // Classify a measured raster; only timing enters the decision.
  function automatic svdd_std_t classify(
    input svdd_words_t tot_w,
    input svdd_words_t act_w,
    input svdd_lines_t tot_l,
    input svdd_lines_t act_l
  );
    logic wide;
    wide = (act_w == `SVDD_ACT_1440);
    classify = SVDD_STD_UNKNOWN;
    if (tot_w == `SVDD_TOT_525 && tot_l == `SVDD_LINES_525) begin
      if (act_l == `SVDD_ACT_487) begin
        classify = wide ? SVDD_STD_525_487 : SVDD_STD_525_487_GEN;
      end else if (act_l == `SVDD_ACT_507) begin
        classify = wide ? SVDD_STD_525_507 : SVDD_STD_525_507_GEN;
      end
    end else if (tot_w == `SVDD_TOT_625 && tot_l == `SVDD_LINES_625) begin
      classify = wide ? SVDD_STD_625_1440 : SVDD_STD_625_GEN;
    end
  endfunction

  // Map the receiver mode and any SDTI header type to a format code.
  // An SDTI type outside 0 to 5 falls back to unknown, so that no
  // reserved code can ever reach the host.
  function automatic svdd_fmt_t format_of(
    input logic asi,
    input logic sdti,
    input logic [2:0] kind
  );
    format_of = SVDD_FMT_SDI;
    if (asi) begin
      format_of = SVDD_FMT_ASI;
    end else if (sdti) begin
      case (kind)
        3'h0: format_of = SVDD_FMT_TAPE_NOECC;
        3'h1: format_of = SVDD_FMT_TAPE_ECC;
        3'h2: format_of = SVDD_FMT_TAPE_B;
        3'h3: format_of = SVDD_FMT_CONTENT_PKG;
        3'h4: format_of = SVDD_FMT_FIXED_BLK;
        3'h5: format_of = SVDD_FMT_VAR_BLK;
        default: format_of = SVDD_FMT_UNKNOWN;
      endcase
    end
  endfunction

  svdd_meas_if meas ();

  // The raster meter works from reference word timing only.
  svdd_raster_meter u_meter (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .trs_valid_i(TRS_VALID_I),
    .trs_eav_i(TRS_EAV_I),
    .trs_f_i(TRS_F_I),
    .trs_v_i(TRS_V_I),
    .meas(meas)
  );

  svdd_words_t act_words_reg, tot_words_reg;
  svdd_lines_t tot_lines_reg, fld_lines_reg;
  svdd_std_t std_code_reg;
  logic sync_lock_reg;
  svdd_fmt_t fmt_reg;
  logic [15:0] rdata_reg;
  logic rvalid_reg;
  logic pid_clear_reg;

  // Loss of lock or a low bypass pin blanks the standard.
  wire std_blank = ~LOCKED_I | ~VIDEO_PROCESSING_BYPASS_N_I;
  wire fmt_blank = ~LOCKED_I | DATA_THROUGH_I;

  // Next values of the status fields.
  wire svdd_std_t std_code_next = std_blank ? SVDD_STD_NONE
    : meas.upd ? classify(meas.tot_words, meas.act_words,
                          meas.tot_lines, meas.frm_act_lines)
    : std_code_reg;
  wire sync_lock_next = SIGNAL_PRESENT_I ? FLYWHEEL_FULL_SYNC_I
    : sync_lock_reg;
  wire svdd_fmt_t fmt_next = fmt_blank ? SVDD_FMT_UNKNOWN
    : format_of(ASI_MODE_I, SDTI_VALID_I, SDTI_FORMAT_I);

  // Status word layout; unused bits read as zero.
  wire [15:0] status_word = {1'b0, std_code_reg, 1'b0,
    sync_lock_reg, 4'h0, fmt_reg};

  // Read decode; an unmapped offset returns zero.
  wire [15:0] rd_word =
    (HOST_ADDR_I == `SVDD_OFS_STATUS) ? status_word
    : (HOST_ADDR_I == `SVDD_OFS_ACT_WORDS) ? {4'h0, act_words_reg}
    : (HOST_ADDR_I == `SVDD_OFS_TOT_WORDS) ? {4'h0, tot_words_reg}
    : (HOST_ADDR_I == `SVDD_OFS_TOT_LINES) ? {5'h00, tot_lines_reg}
    : (HOST_ADDR_I == `SVDD_OFS_FLD_LINES) ? {5'h00, fld_lines_reg}
    : 16'h0000;

  // Raster registers load only on the end-of-line-12 pulse.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      act_words_reg <= `SVDD_WORDS_RST;
      tot_words_reg <= `SVDD_WORDS_RST;
      tot_lines_reg <= `SVDD_LINES_RST;
      fld_lines_reg <= `SVDD_LINES_RST;
    end else if (meas.upd) begin
      act_words_reg <= meas.act_words;
      tot_words_reg <= meas.tot_words;
      tot_lines_reg <= meas.tot_lines;
      fld_lines_reg <= meas.fld_act_lines;
    end
  end

  // Status fields; nothing on the host side reaches them, so a write
  // strobe has no path into this state.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      std_code_reg <= SVDD_STD_NONE;
      sync_lock_reg <= 1'b0;
      fmt_reg <= SVDD_FMT_UNKNOWN;
      pid_clear_reg <= 1'b1;
    end else begin
      std_code_reg <= std_code_next;
      sync_lock_reg <= sync_lock_next;
      fmt_reg <= fmt_next;
      pid_clear_reg <= std_blank;
    end
  end

  // Read data is held in a register and answered one cycle later.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= HOST_RD_I;
      if (HOST_RD_I) rdata_reg <= rd_word;
    end
  end

  assign HOST_RDATA_O = rdata_reg;
  assign HOST_RVALID_O = rvalid_reg;
  assign PAYLOAD_ID_CLEAR_O = pid_clear_reg;

  // Checks on the registered state.
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  raster_hold_between_a: assert property (
    !meas.upd |=> $stable(tot_words_reg) && $stable(act_words_reg)
      && $stable(tot_lines_reg) && $stable(fld_lines_reg))
    else $error("Raster register changed without an update.");

  raster_load_a: assert property (
    meas.upd |=> tot_words_reg == $past(meas.tot_words)
      && fld_lines_reg == $past(meas.fld_act_lines))
    else $error("Raster register did not take the measurement.");

  std_blank_zero_a: assert property (
    std_blank |=> std_code_reg == SVDD_STD_NONE)
    else $error("Standard code not zero while unlocked or bypassed.");

  lock_follow_a: assert property (
    SIGNAL_PRESENT_I |=> sync_lock_reg == $past(FLYWHEEL_FULL_SYNC_I))
    else $error("Sync-lock bit does not follow the flywheel.");

  lock_hold_a: assert property (
    !SIGNAL_PRESENT_I |=> $stable(sync_lock_reg))
    else $error("Sync-lock bit moved while the input was absent.");

  fmt_unknown_a: assert property (
    fmt_blank |=> fmt_reg == SVDD_FMT_UNKNOWN)
    else $error("Format not unknown while unlocked or passing through.");

  fmt_no_reserved_a: assert property (
    !(fmt_reg inside {[4'h8:4'he]}))
    else $error("Reserved format code reported.");

  std_code_legal_a: assert property (
    std_code_reg inside {SVDD_STD_NONE, SVDD_STD_525_487,
      SVDD_STD_525_507, SVDD_STD_625_1440, SVDD_STD_525_487_GEN,
      SVDD_STD_625_GEN, SVDD_STD_525_507_GEN, SVDD_STD_UNKNOWN})
    else $error("Reserved standard code reported.");

  std_625_a: assert property (
    meas.upd && !std_blank && meas.tot_words == `SVDD_TOT_625
      && meas.tot_lines == `SVDD_LINES_625
      && meas.act_words == `SVDD_ACT_1440
    |=> std_code_reg == SVDD_STD_625_1440)
    else $error("625-line 1440 raster not reported as 18h.");

  status_read_a: assert property (
    HOST_RD_I && HOST_ADDR_I == `SVDD_OFS_STATUS
    |=> HOST_RVALID_O
      && HOST_RDATA_O[`SVDD_STD_MSB:`SVDD_STD_LSB] == $past(std_code_reg)
      && HOST_RDATA_O[`SVDD_LOCK_BIT] == $past(sync_lock_reg))
    else $error("Status read returned the wrong fields.");

  write_no_answer_a: assert property (
    HOST_WR_I && !HOST_RD_I |=> !HOST_RVALID_O)
    else $error("A write produced a read answer.");

  pid_clear_a: assert property (
    std_blank |=> PAYLOAD_ID_CLEAR_O ##1 PAYLOAD_ID_CLEAR_O || !$past(
      std_blank))
    else $error("Payload identifier clear not raised.");

  // Classification and hold of the standard code. The two 525-line
  // formats share one line length, so only the frame active lines
  // can tell them apart.
  std_525_a: assert property (
    meas.upd && !std_blank && meas.tot_words == `SVDD_TOT_525
      && meas.tot_lines == `SVDD_LINES_525
      && meas.frm_act_lines == `SVDD_ACT_487
      && meas.act_words == `SVDD_ACT_1440
    |=> std_code_reg == SVDD_STD_525_487)
    else $error("525-line 487 raster not reported as 16h.");

  std_other_a: assert property (
    meas.upd && !std_blank && meas.tot_words != `SVDD_TOT_525
      && meas.tot_words != `SVDD_TOT_625
    |=> std_code_reg == SVDD_STD_UNKNOWN)
    else $error("Unlisted raster not reported as 1Eh.");

  std_hold_a: assert property (
    !meas.upd && !std_blank |=> $stable(std_code_reg))
    else $error("Standard code changed between frame updates.");

  // Format selection; an ASI stream wins over any SDTI header.
  fmt_asi_a: assert property (
    !fmt_blank && ASI_MODE_I |=> fmt_reg == SVDD_FMT_ASI)
    else $error("ASI stream not reported as 7h.");

  fmt_sdi_a: assert property (
    !fmt_blank && !ASI_MODE_I && !SDTI_VALID_I
    |=> fmt_reg == SVDD_FMT_SDI)
    else $error("Plain SDI not reported as 6h.");

  fmt_sdti_a: assert property (
    !fmt_blank && !ASI_MODE_I && SDTI_VALID_I && SDTI_FORMAT_I < 3'h6
    |=> fmt_reg == {1'b0, $past(SDTI_FORMAT_I)})
    else $error("SDTI header type not reported as its format code.");

  // Host side: every read is answered one cycle later with the word.
  read_answer_a: assert property (
    HOST_RD_I |=> HOST_RVALID_O)
    else $error("Read strobe not answered in one cycle.");

  total_words_read_a: assert property (
    HOST_RD_I && HOST_ADDR_I == `SVDD_OFS_TOT_WORDS
    |=> HOST_RDATA_O == {4'h0, $past(tot_words_reg)})
    else $error("Total line words read returned the wrong value.");

  fld_lines_read_a: assert property (
    HOST_RD_I && HOST_ADDR_I == `SVDD_OFS_FLD_LINES
    |=> HOST_RDATA_O == {5'h00, $past(fld_lines_reg)})
    else $error("Field active lines read returned the wrong value.");

  // Main scenarios.
  upd_seen_c: cover property (meas.upd && !std_blank);
  std_525_c: cover property (std_code_reg == SVDD_STD_525_487);
  asi_fmt_c: cover property (fmt_reg == SVDD_FMT_ASI);
  lock_held_c: cover property (!SIGNAL_PRESENT_I && sync_lock_reg);
  sdti_fmt_c: cover property (fmt_reg == SVDD_FMT_VAR_BLK);

endmodule // svdd_std_detector

//--- verif/tb_top.sv
`include "svdd_defines.svh"

module tb_top
  import svdd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk, rst, trs_valid, trs_eav, trs_f, trs_v, locked, byp_n;
  logic data_thru, fsync, sig_pres, asi, sdti_v, host_rd, host_wr;
  logic rvalid, pid_clr;
  logic [2:0] sdti_fmt;
  logic [7:0] host_addr, ra;
  logic [15:0] rdata;
  int err_count, checks;
  integer seed = 32'hf4c2efdb;
  logic [11:0] e_act, e_tot;
  logic [10:0] e_lines, e_fld;
  logic [4:0] e_std;
  logic e_lock;
  logic [3:0] e_fmt;
  event ev_old, ev_new;

  svdd_std_detector dut (
    .REF_CLK_I(ref_clk), .RST_I(rst), .TRS_VALID_I(trs_valid),
    .TRS_EAV_I(trs_eav), .TRS_F_I(trs_f), .TRS_V_I(trs_v),
    .LOCKED_I(locked), .VIDEO_PROCESSING_BYPASS_N_I(byp_n),
    .DATA_THROUGH_I(data_thru), .FLYWHEEL_FULL_SYNC_I(fsync),
    .SIGNAL_PRESENT_I(sig_pres), .ASI_MODE_I(asi), .SDTI_VALID_I(sdti_v),
    .SDTI_FORMAT_I(sdti_fmt), .HOST_ADDR_I(host_addr), .HOST_RD_I(host_rd),
    .HOST_WR_I(host_wr), .HOST_RDATA_O(rdata), .HOST_RVALID_O(rvalid),
    .PAYLOAD_ID_CLEAR_O(pid_clr));

  // Free-running 250 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Pass-through and unlock both win over any detected format.
  function automatic logic [3:0] fmt_of(input logic lk, dt, a, sv,
                                        input logic [2:0] k);
    if (!lk || dt) return 4'hf;
    if (a) return 4'h7;
    if (sv) return (k < 3'h6) ? {1'b0, k} : 4'hf;
    return 4'h6;
  endfunction

  // Expected read data of every offset; anything unmapped reads zero.
  function automatic logic [15:0] exp_reg(input logic [7:0] a);
    case (a)
      `SVDD_OFS_STATUS: return {1'b0, e_std, 1'b0, e_lock, 4'h0, e_fmt};
      `SVDD_OFS_ACT_WORDS: return {4'h0, e_act};
      `SVDD_OFS_TOT_WORDS: return {4'h0, e_tot};
      `SVDD_OFS_TOT_LINES: return {5'h00, e_lines};
      `SVDD_OFS_FLD_LINES: return {5'h00, e_fld};
      default: return 16'h0000;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Status inputs take effect at the edge that registers them.
  task automatic model_step();
    if (sig_pres) e_lock = fsync;
    if (!locked || !byp_n) e_std = 5'h00;
    e_fmt = fmt_of(locked, data_thru, asi, sdti_v, sdti_fmt);
  endtask

  // The strobe is left high so back-to-back reads never toggle it.
  task automatic rd_chk(input logic [7:0] a);
    host_addr = a;
    host_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    chk("read valid", {15'h0000, rvalid}, 16'h0001);
    chk($sformatf("reg %h", a), rdata, exp_reg(a));
  endtask

  task automatic do_reset();
    rst = 1'b1;
    {e_act, e_tot, e_lines, e_fld, e_std, e_lock} = '0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("payload clear", {15'h0000, pid_clr}, 16'h0001);
    rst = 1'b0;
    @(posedge ref_clk);
    #1;
    model_step();
  endtask

  // One line: EAV at word 0, SAV at word sav; ln is frame * 100 + line,
  // and the events mark the check points.
  task automatic send_line(input int len, sav, input logic f, v,
                           input int ln);
    for (int c = 0; c < len; c++) begin
      trs_valid = (c == 0) || (c == sav);
      trs_eav = (c == 0);
      trs_f = f;
      trs_v = v;
      if (c == 0 && ln == 11) -> ev_old;
      if (c == 0 && ln == 114) -> ev_new;
      @(posedge ref_clk);
      #1;
    end
  endtask

  // A lead-in line with F high, then two frames. Reset values are read
  // in frame 0 before its line-12 update; frame 0's figures are read
  // after the line-12 update of frame 1.
  task automatic run_test(input int len, sav, n, vb);
    do_reset();
    fork
      begin
        send_line(len, sav, 1'b1, 1'b1, 0);
        for (int fr = 0; fr < 2; fr++)
          for (int j = 1; j <= n; j++)
            send_line(len, sav, j > n / 2,
                      (j <= vb) || (j > n / 2 && j <= n / 2 + vb),
                      fr * 100 + j);
        trs_valid = 1'b0;
      end
      begin
        @ev_old;
        for (int i = 0; i < 5; i++)
          rd_chk(i == 0 ? 8'h04 : 8'(8'h0d + i));
        host_rd = 1'b0;
        @ev_new;
        e_act = 12'(len - sav - 4);
        e_tot = 12'(len);
        e_lines = 11'(n);
        e_fld = 11'(n / 2 - vb);
        e_std = SVDD_STD_UNKNOWN;
        rd_chk(`SVDD_OFS_STATUS);
        for (int i = 1; i < 5; i++) rd_chk(8'(8'h0d + i));
        host_rd = 1'b0;
      end
    join
  endtask

  task automatic conclude();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang in a bounded wait ends the run as a failure.
  initial begin
    #300000;
    err_count++;
    conclude();
  end

  // Reset defaults, write refusal, three rasters, then random status.
  initial begin
    {trs_valid, trs_eav, trs_f, trs_v, asi, sdti_v, sig_pres} = '0;
    {host_rd, host_wr, sdti_fmt, host_addr} = '0;
    {locked, byp_n, data_thru, fsync, rst} = '1;
    err_count = 0;
    checks = 0;
    #1;
    do_reset();
    for (int i = 0; i < 6; i++)
      rd_chk(i == 0 ? 8'h04 : 8'(8'h0c + i));
    host_rd = 1'b0;
    host_wr = 1'b1;
    host_addr = `SVDD_OFS_STATUS;
    @(posedge ref_clk);
    #1;
    host_wr = 1'b0;
    chk("write answer", {15'h0000, rvalid}, 16'h0000);
    rd_chk(`SVDD_OFS_STATUS);
    host_rd = 1'b0;
    data_thru = 1'b0;
    sig_pres = 1'b1;
    run_test(24, 6, 28, 2);
    repeat (2)
      run_test(30 + $unsigned($random(seed)) % 32,
               6 + $unsigned($random(seed)) % 8,
               28 + 2 * ($unsigned($random(seed)) % 8),
               2 + $unsigned($random(seed)) % 4);
    repeat (80) begin
      {locked, byp_n, data_thru, fsync, sig_pres, asi, sdti_v} =
        7'($random(seed)) | 7'h40;
      if ($unsigned($random(seed)) % 5 == 0) locked = 1'b0;
      sdti_fmt = 3'($random(seed));
      ra = ($random(seed) & 1) ? 8'h04 : 8'($random(seed)) & 8'h1f;
      host_wr = 1'($random(seed));
      host_addr = ra;
      @(posedge ref_clk);
      #1;
      host_wr = 1'b0;
      model_step();
      chk("payload clear", {15'h0000, pid_clr},
          {15'h0000, !locked || !byp_n});
      rd_chk(ra);
    end
    host_rd = 1'b0;
    conclude();
  end
endmodule // tb_top
